//--- rtl/fcis_pkg.sv
// fcis_pkg: register map, reset values, interpolation constants and carrier types
package fcis_pkg;

	// ****************************************************************
	// register offsets (15-bit serial address space)
	// ****************************************************************
	localparam int          ADDR_W          = 15;
	localparam logic [14:0] ADDR_STOP       = 15'h0011;
	localparam logic [14:0] ADDR_START      = 15'h0012;
	localparam logic [14:0] ADDR_DIR        = 15'h0013;
	localparam logic [14:0] ADDR_PTR        = 15'h0014;
	localparam logic [14:0] ADDR_WR_CENTER  = 15'h0020;
	localparam logic [14:0] ADDR_WR_BW      = 15'h0021;
	localparam logic [14:0] ADDR_WR_MATCH   = 15'h0022;
	localparam logic [14:0] ADDR_FC_COEFF   = 15'h0040;
	localparam logic [14:0] ADDR_FC_LAST    = 15'h0049;
	localparam logic [14:0] ADDR_BW_COEFF   = 15'h004a;
	localparam logic [14:0] ADDR_BW_LAST    = 15'h004c;
	localparam logic [14:0] ADDR_MT_COEFF   = 15'h004d;
	localparam logic [14:0] ADDR_MT_LAST    = 15'h004f;
	localparam logic [14:0] ADDR_INTERP     = 15'h0050;
	localparam logic [14:0] ADDR_APP_CENTER = 15'h0060;
	localparam logic [14:0] ADDR_APP_BW     = 15'h0061;
	localparam logic [14:0] ADDR_APP_MATCH  = 15'h0062;
	localparam logic [14:0] ADDR_LUT_FIRST  = 15'h0100;
	localparam logic [14:0] ADDR_LUT_LAST   = 15'h015f;

	// ****************************************************************
	// sizes, field positions and reset values
	// ****************************************************************
	localparam int         LUT_BYTES   = 96;
	localparam int         GROUP_BYTES = 3;
	localparam int         PTR_W       = 7;
	localparam int         DIR_BIT     = 0;
	localparam int         INTERP_BIT  = 0;
	localparam logic [6:0] STOP_RESET  = 7'h7f;
	localparam logic [6:0] START_RESET = 7'h00;
	localparam logic [6:0] PTR_RESET   = 7'h00;
	localparam logic [7:0] BYTE_RESET  = 8'h00;
	localparam logic [9:0][7:0] FC_COEFF_RESET = {8'h15, 8'h1b, 8'h22, 8'h2d, 8'h3b,
	                                              8'h4e, 8'h6a, 8'h96, 8'hb4, 8'hdb};
	localparam logic [2:0][7:0] BW_COEFF_RESET = {8'h1d, 8'h04, 8'h00};
	localparam logic [2:0][7:0] MT_COEFF_RESET = {8'h6a, 8'h11, 8'h00};

	// ****************************************************************
	// interpolation constants
	// ****************************************************************
	localparam int SEG0_END   = 16;
	localparam int SEG1_END   = 32;
	localparam int SEG_WIDTH  = 32;
	localparam int FINE_SHIFT = 4;
	localparam int WIDE_SHIFT = 5;
	localparam int X_TOP      = 255;
	localparam int Y_KNEE     = 32;
	localparam int KNEE_SLOPE = 295;
	localparam int KNEE_SHIFT = 16;

	// ****************************************************************
	// serial framing
	// ****************************************************************
	localparam logic [4:0] HDR_BITS = 5'h10;
	localparam logic [2:0] BYTE_END = 3'h7;

	// ****************************************************************
	// carrier types
	// ****************************************************************
	typedef struct packed {
		logic [9:0][7:0] fc;
		logic [2:0][7:0] bw;
		logic [2:0][7:0] mt;
	} fcis_coeff_t;

	typedef struct packed {
		logic [7:0] center;
		logic [7:0] bw;
		logic [7:0] match;
	} fcis_codes_t;

	typedef struct packed {
		logic [14:0] addr;
		logic [7:0]  data;
	} fcis_wr_t;

endpackage : fcis_pkg

//--- rtl/fcis_core.sv
// fcis_core: serial register port, lookup-table sequencer and capacitor code interpolation
`timescale 1ns/1ps
`default_nettype none

// Contract
// - x is the full 8-bit center load
// - x below 16: fine segment, shift 4
// - x 16 to 31: second fine segment
// - 32-wide segments up to 223, shift 5
// - last segment to 254, 255 gives coeff 9
// - bandwidth below y 32: shift 5 form
// - bandwidth above knee: times 295, shift 16
// - match code uses same knee form
// - applied codes readable at applied_center_code-applied_match_code
// - 32-group table with sequencing machine
// - fast latch steps on chip-select rise
// - table mapped at 0x100 to 0x15f
// - stop, start, direction, pointer registers
// - pointer names next group to apply
// - direction 0 increments, 1 decrements
// - step between bounds, wrap at end
// - outside fast latch, edge reloads pointer
// - interpolation only while enable set
// - write group supplies three load values
// - loads and codes are 8 bits
module fcis_core (
	input  wire logic clk_in,
	input  wire logic arst_n_in,
	input  wire logic clk_en_in,
	input  wire logic spi_sclk_in,
	input  wire logic spi_cs_n_in,
	input  wire logic spi_sdi_in,
	input  wire logic fast_latch_sel_in,
	output var  logic spi_sdo_out,
	output var  logic spi_sdo_oe_n_out,
	output var  logic [7:0] center_cap_code_out,
	output var  logic [7:0] bandwidth_cap_code_out,
	output var  logic [7:0] match_cap_code_out
);

	// every check below samples on the core clock and sleeps through reset
	default clocking core_cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);

	// ****************************************************************
	// arithmetic helpers
	// ****************************************************************

	// piecewise center curve; int intermediates hold every product
	function automatic logic [7:0] fcis_center_interp(input logic [7:0] x,
	                                                  input logic [9:0][7:0] c);
		int k;
		int seg_end;
		int sh;
		int prod;
		int res;
		k = 0;
		seg_end = fcis_pkg::SEG0_END;
		sh = fcis_pkg::FINE_SHIFT;
		if (int'(x) < fcis_pkg::SEG0_END) begin
			k = 0;
		end else if (int'(x) < fcis_pkg::SEG1_END) begin
			k = 1;
			seg_end = fcis_pkg::SEG1_END;
		end else begin
			k = int'(x[7:5]) + 1;
			seg_end = (int'(x[7:5]) + 1) * fcis_pkg::SEG_WIDTH;
			sh = fcis_pkg::WIDE_SHIFT;
		end
		prod = (seg_end - int'(x)) * (int'(c[k]) - int'(c[k + 1]));
		res = int'(c[k + 1]) + (prod >>> sh);
		if (int'(x) >= fcis_pkg::X_TOP) begin
			res = int'(c[9]);
		end
		return res[7:0];
	endfunction : fcis_center_interp

	// two-segment curve shared by bandwidth and match codes
	function automatic logic [7:0] fcis_knee_interp(input logic [7:0] y,
	                                                input logic [2:0][7:0] c);
		int res;
		res = int'(c[2]);
		if (int'(y) < fcis_pkg::Y_KNEE) begin
			res = int'(c[0]) + ((int'(y) * (int'(c[1]) - int'(c[0]))) >>> fcis_pkg::WIDE_SHIFT);
		end else if (int'(y) < fcis_pkg::X_TOP) begin
			res = int'(c[1]) + (((int'(y) - fcis_pkg::Y_KNEE) * (int'(c[2]) - int'(c[1]))
			      * fcis_pkg::KNEE_SLOPE) >>> fcis_pkg::KNEE_SHIFT);
		end
		return res[7:0];
	endfunction : fcis_knee_interp

	// ****************************************************************
	// state declarations
	// ****************************************************************
	logic               spi_rst_n;
	logic [4:0]         hdr_cnt;
	logic [15:0]        hdr_sh;
	logic               rd_mode;
	logic [14:0]        cur_addr;
	logic [2:0]         bit_idx;
	logic [6:0]         data_sh;
	logic [6:0]         rd_sh;
	logic [7:0]         rd_byte;
	fcis_pkg::fcis_wr_t wr_hold;
	logic               wr_tgl;
	logic [2:0]         wr_tgl_sync;
	logic [2:0]         cs_sync;
	logic [1:0]         sfl_sync;
	logic               wr_fire;
	logic               cs_rise;
	logic               fast_latch_sel;
	logic [6:0]         stop_idx;
	logic [6:0]         start_idx;
	logic               dir;
	logic [6:0]         ptr;
	logic               interp_enable;
	fcis_pkg::fcis_codes_t wr_group;
	fcis_pkg::fcis_codes_t fl_group;
	fcis_pkg::fcis_codes_t loads;
	fcis_pkg::fcis_codes_t applied;
	fcis_pkg::fcis_coeff_t coeff;
	logic [7:0]         lut [0:fcis_pkg::LUT_BYTES-1];
	logic [7:0]         interp_y;
	logic [6:0]         lut_base;

	// ****************************************************************
	// serial port, link clock domain
	// ****************************************************************

	// a high chip select clears the frame state; the link clock may stop between frames
	assign spi_rst_n = arst_n_in & ~spi_cs_n_in;

	// header: read flag then 15 address bits, then data bytes with ascending address
	always_ff @(posedge spi_sclk_in or negedge spi_rst_n) begin
		if (!spi_rst_n) begin
			hdr_cnt  <= 5'h00;
			hdr_sh   <= 16'h0000;
			rd_mode  <= 1'b0;
			cur_addr <= 15'h0000;
			bit_idx  <= 3'h0;
			data_sh  <= 7'h00;
		end else if (hdr_cnt != fcis_pkg::HDR_BITS) begin
			hdr_sh  <= {hdr_sh[14:0], spi_sdi_in};
			hdr_cnt <= hdr_cnt + 5'h01;
			if (hdr_cnt == fcis_pkg::HDR_BITS - 5'h01) begin
				rd_mode  <= hdr_sh[14];
				cur_addr <= {hdr_sh[13:0], spi_sdi_in};
			end
		end else begin
			data_sh <= {data_sh[5:0], spi_sdi_in};
			bit_idx <= bit_idx + 3'h1;
			if (bit_idx == fcis_pkg::BYTE_END) begin
				cur_addr <= cur_addr + 15'h0001;
			end
		end
	end

	// write words survive the frame end, so only the chip reset clears them
	always_ff @(posedge spi_sclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wr_hold <= '0;
			wr_tgl  <= 1'b0;
		end else if (spi_rst_n && hdr_cnt == fcis_pkg::HDR_BITS &&
		             bit_idx == fcis_pkg::BYTE_END && !rd_mode) begin
			wr_hold <= '{addr: cur_addr, data: {data_sh, spi_sdi_in}};
			wr_tgl  <= ~wr_tgl; // held a whole byte time, ample for the crossing
		end
	end

	// read mux: sources only change on writes, chip-select rises or mode pin changes
	always_comb begin
		rd_byte = 8'h00;
		if (cur_addr == fcis_pkg::ADDR_STOP) begin
			rd_byte = {1'b0, stop_idx};
		end else if (cur_addr == fcis_pkg::ADDR_START) begin
			rd_byte = {1'b0, start_idx};
		end else if (cur_addr == fcis_pkg::ADDR_DIR) begin
			rd_byte = {7'h00, dir};
		end else if (cur_addr == fcis_pkg::ADDR_PTR) begin
			rd_byte = {1'b0, ptr};
		end else if (cur_addr == fcis_pkg::ADDR_WR_CENTER) begin
			rd_byte = wr_group.center;
		end else if (cur_addr == fcis_pkg::ADDR_WR_BW) begin
			rd_byte = wr_group.bw;
		end else if (cur_addr == fcis_pkg::ADDR_WR_MATCH) begin
			rd_byte = wr_group.match;
		end else if (cur_addr >= fcis_pkg::ADDR_FC_COEFF && cur_addr <= fcis_pkg::ADDR_FC_LAST) begin
			rd_byte = coeff.fc[cur_addr[3:0]];
		end else if (cur_addr >= fcis_pkg::ADDR_BW_COEFF && cur_addr <= fcis_pkg::ADDR_BW_LAST) begin
			rd_byte = coeff.bw[2'(cur_addr - fcis_pkg::ADDR_BW_COEFF)];
		end else if (cur_addr >= fcis_pkg::ADDR_MT_COEFF && cur_addr <= fcis_pkg::ADDR_MT_LAST) begin
			rd_byte = coeff.mt[2'(cur_addr - fcis_pkg::ADDR_MT_COEFF)];
		end else if (cur_addr == fcis_pkg::ADDR_INTERP) begin
			rd_byte = {7'h00, interp_enable};
		end else if (cur_addr == fcis_pkg::ADDR_APP_CENTER) begin
			rd_byte = applied.center;
		end else if (cur_addr == fcis_pkg::ADDR_APP_BW) begin
			rd_byte = applied.bw;
		end else if (cur_addr == fcis_pkg::ADDR_APP_MATCH) begin
			rd_byte = applied.match;
		end else if (cur_addr >= fcis_pkg::ADDR_LUT_FIRST && cur_addr <= fcis_pkg::ADDR_LUT_LAST) begin
			rd_byte = lut[7'(cur_addr - fcis_pkg::ADDR_LUT_FIRST)];
		end
	end

	// read data leaves msb first on falling edges; driver enabled after the header
	always_ff @(negedge spi_sclk_in or negedge spi_rst_n) begin
		if (!spi_rst_n) begin
			spi_sdo_out      <= 1'b0;
			spi_sdo_oe_n_out <= 1'b1;
			rd_sh            <= 7'h00;
		end else if (hdr_cnt == fcis_pkg::HDR_BITS && rd_mode) begin
			spi_sdo_oe_n_out <= 1'b0;
			if (bit_idx == 3'h0) begin
				spi_sdo_out <= rd_byte[7];
				rd_sh       <= rd_byte[6:0];
			end else begin
				spi_sdo_out <= rd_sh[6];
				rd_sh       <= {rd_sh[5:0], 1'b0};
			end
		end
	end

	// ****************************************************************
	// crossings into the core clock
	// ****************************************************************

	// two stages for every pin level, a third only feeds edge detection
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wr_tgl_sync <= 3'h0;
			cs_sync     <= 3'h7;
			sfl_sync    <= 2'h0;
		end else if (clk_en_in) begin
			wr_tgl_sync <= {wr_tgl_sync[1:0], wr_tgl};
			cs_sync     <= {cs_sync[1:0], spi_cs_n_in};
			sfl_sync    <= {sfl_sync[0], fast_latch_sel_in};
		end
	end

	assign wr_fire = clk_en_in && (wr_tgl_sync[2] != wr_tgl_sync[1]);
	assign cs_rise = clk_en_in && cs_sync[1] && !cs_sync[2];
	assign fast_latch_sel     = sfl_sync[1];

	// ****************************************************************
	// register file writes
	// ****************************************************************

	// control, write group and coefficient registers
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			stop_idx      <= fcis_pkg::STOP_RESET;
			start_idx     <= fcis_pkg::START_RESET;
			dir           <= 1'b0;
			interp_enable <= 1'b0;
			wr_group      <= '{center: fcis_pkg::BYTE_RESET, bw: fcis_pkg::BYTE_RESET,
			                   match: fcis_pkg::BYTE_RESET};
			coeff         <= '{fc: fcis_pkg::FC_COEFF_RESET, bw: fcis_pkg::BW_COEFF_RESET,
			                   mt: fcis_pkg::MT_COEFF_RESET};
		end else if (wr_fire) begin
			if (wr_hold.addr == fcis_pkg::ADDR_STOP) begin
				stop_idx <= wr_hold.data[6:0];
			end else if (wr_hold.addr == fcis_pkg::ADDR_START) begin
				start_idx <= wr_hold.data[6:0];
			end else if (wr_hold.addr == fcis_pkg::ADDR_DIR) begin
				dir <= wr_hold.data[fcis_pkg::DIR_BIT];
			end else if (wr_hold.addr == fcis_pkg::ADDR_WR_CENTER) begin
				wr_group.center <= wr_hold.data;
			end else if (wr_hold.addr == fcis_pkg::ADDR_WR_BW) begin
				wr_group.bw <= wr_hold.data;
			end else if (wr_hold.addr == fcis_pkg::ADDR_WR_MATCH) begin
				wr_group.match <= wr_hold.data;
			end else if (wr_hold.addr >= fcis_pkg::ADDR_FC_COEFF &&
			             wr_hold.addr <= fcis_pkg::ADDR_FC_LAST) begin
				coeff.fc[wr_hold.addr[3:0]] <= wr_hold.data;
			end else if (wr_hold.addr >= fcis_pkg::ADDR_BW_COEFF &&
			             wr_hold.addr <= fcis_pkg::ADDR_BW_LAST) begin
				coeff.bw[2'(wr_hold.addr - fcis_pkg::ADDR_BW_COEFF)] <= wr_hold.data;
			end else if (wr_hold.addr >= fcis_pkg::ADDR_MT_COEFF &&
			             wr_hold.addr <= fcis_pkg::ADDR_MT_LAST) begin
				coeff.mt[2'(wr_hold.addr - fcis_pkg::ADDR_MT_COEFF)] <= wr_hold.data;
			end else if (wr_hold.addr == fcis_pkg::ADDR_INTERP) begin
				interp_enable <= wr_hold.data[fcis_pkg::INTERP_BIT];
			end
		end
	end

	// table storage, no reset so it maps to plain memory
	always_ff @(posedge clk_in) begin
		if (wr_fire && wr_hold.addr >= fcis_pkg::ADDR_LUT_FIRST &&
		    wr_hold.addr <= fcis_pkg::ADDR_LUT_LAST) begin
			lut[7'(wr_hold.addr - fcis_pkg::ADDR_LUT_FIRST)] <= wr_hold.data;
		end
	end

	// ****************************************************************
	// fast latch sequencer
	// ****************************************************************

	// byte offset of the group the pointer names; only the low five bits select
	assign lut_base = 7'(ptr[4:0] * fcis_pkg::GROUP_BYTES);

	// pointer moves once per chip-select rise
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ptr <= fcis_pkg::PTR_RESET;
		end else if (cs_rise) begin
			if (!fast_latch_sel) begin
				ptr <= dir ? stop_idx : start_idx;
			end else if (!dir) begin
				ptr <= (ptr == stop_idx) ? start_idx : ptr + 7'h01;
			end else begin
				ptr <= (ptr == start_idx) ? stop_idx : ptr - 7'h01;
			end
		end
	end

	// in fast latch the named group is taken before the pointer moves on
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			fl_group <= '0;
		end else if (cs_rise && fast_latch_sel) begin
			fl_group <= '{center: lut[lut_base], bw: lut[lut_base + 7'h01],
			              match: lut[lut_base + 7'h02]};
		end
	end

	// ****************************************************************
	// capacitor code generation
	// ****************************************************************

	// load source follows the mode pin; the table group holds until the next edge
	assign loads    = fast_latch_sel ? fl_group : wr_group;
	assign interp_y = fcis_center_interp(loads.center, coeff.fc);

	// one register stage keeps the code outputs glitch free
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			applied <= '0;
		end else if (clk_en_in) begin
			if (interp_enable) begin
				applied <= '{center: interp_y, bw: fcis_knee_interp(interp_y, coeff.bw),
				             match: fcis_knee_interp(interp_y, coeff.mt)};
			end else begin
				applied <= loads;
			end
		end
	end

	assign center_cap_code_out    = applied.center;
	assign bandwidth_cap_code_out = applied.bw;
	assign match_cap_code_out     = applied.match;

	// ****************************************************************
	// assertions
	// ****************************************************************
	ptr_step_up_a: assert property (cs_rise && fast_latch_sel && !dir && ptr != stop_idx |=>
		ptr == $past(ptr) + 7'h01) else $error("pointer did not increment");
	ptr_wrap_start_a: assert property (cs_rise && fast_latch_sel && !dir && ptr == stop_idx |=>
		ptr == $past(start_idx)) else $error("pointer did not wrap to start");
	ptr_step_down_a: assert property (cs_rise && fast_latch_sel && dir && ptr != start_idx |=>
		ptr == $past(ptr) - 7'h01) else $error("pointer did not decrement");
	ptr_reload_a: assert property (cs_rise && !fast_latch_sel |=>
		ptr == ($past(dir) ? $past(stop_idx) : $past(start_idx)))
		else $error("pointer not reloaded outside fast latch");
	ptr_hold_a: assert property (!cs_rise |=> $stable(ptr))
		else $error("pointer moved without a chip-select rise");
	group_take_a: assert property (cs_rise && fast_latch_sel |=>
		fl_group.center == $past(lut[lut_base])) else $error("table group not taken on edge");
	direct_pass_a: assert property (clk_en_in && !interp_enable && !fast_latch_sel ##1
		clk_en_in && !interp_enable && !fast_latch_sel && $stable(wr_group) |-> ##1
		applied == $past(wr_group, 2)) else $error("loads not passed straight through");
	top_code_a: assert property (clk_en_in && interp_enable && loads.center == 8'hff |=>
		applied.center == $past(coeff.fc[9])) else $error("center code at 255 not coefficient 9");
	low_end_a: assert property (clk_en_in && interp_enable && loads.center == 8'h00 |=>
		applied.center == $past(coeff.fc[0])) else $error("center code at 0 not coefficient 0");
	knee_bw_a: assert property (clk_en_in && interp_enable && interp_y == 8'h20 |=>
		applied.bw == $past(coeff.bw[1]) && applied.match == $past(coeff.mt[1]))
		else $error("codes at knee are not coefficient 1");
	knee_top_a: assert property (clk_en_in && interp_enable && interp_y == 8'hff |=>
		applied.match == $past(coeff.mt[2])) else $error("match code at top not coefficient 2");
	write_group_a: assert property (wr_fire && wr_hold.addr == fcis_pkg::ADDR_WR_CENTER |=>
		wr_group.center == $past(wr_hold.data)) else $error("center load write lost");
	wrap_seen_c: cover property (cs_rise && fast_latch_sel && !dir && ptr == stop_idx);
	down_seen_c: cover property (cs_rise && fast_latch_sel && dir);
	interp_seen_c: cover property (clk_en_in && interp_enable && loads.center == 8'hb4);
	reload_seen_c: cover property (cs_rise && !fast_latch_sel && dir);

endmodule : fcis_core

`default_nettype wire

//--- verification/fcis_host.sv
// fcis_host: serial host model driving chip select, serial clock, data and fast latch select
`timescale 1ns/1ps
`default_nettype none
module fcis_host (
	output var  logic sclk_out,
	output var  logic cs_n_out,
	output var  logic sdi_out,
	output var  logic sfl_out,
	input  wire logic sdo_in
);
	// ****************************************************************
	// frame, pulse and mode tasks
	// ****************************************************************
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		sdi_out  = 1'b0;
		sfl_out  = 1'b0;
	end

	// one 24-bit frame; the serial clock stands still outside it
	task automatic frame(input logic rd, input logic [14:0] a, input logic [7:0] d,
		output logic [7:0] q);
		logic [23:0] bits;
		bits = {rd, a, d};
		q = 8'h00;
		cs_n_out = 1'b0;
		#100;
		for (int i = 23; i >= 0; i--) begin
			sdi_out = bits[i];
			#62.5 sclk_out = 1'b1;
			if (i < 8) q[i] = sdo_in; // data settled since the falling edge
			#62.5 sclk_out = 1'b0;
		end
		#100 cs_n_out = 1'b1;
		sdi_out = ~sdi_out; // released line must not look held
		#300;
	endtask : frame

	// bare chip-select pulse: steps or reloads the pointer
	task automatic pulse();
		cs_n_out = 1'b0;
		#100 cs_n_out = 1'b1;
		#300;
	endtask : pulse

	// mode change, given time to pass the two-stage sync
	task automatic set_sfl(input logic v);
		sfl_out = v;
		#100;
	endtask : set_sfl
endmodule : fcis_host
`default_nettype wire

//--- verification/filter_code_interp_sequencer_bench.sv
// filter_code_interp_sequencer_bench: self-checking bench for the filter code core
`timescale 1ns/1ps
`default_nettype none
module filter_code_interp_sequencer_bench;
	logic       clk_in    = 1'b0;
	logic       arst_n_in = 1'b0;
	logic       clk_en    = 1'b1;
	wire  logic sclk, cs_n, sdi, fast_latch_sel, sdo, oe_n, sdo_w;
	wire  logic [7:0] cc, bc, mc;
	int         fails, samples_checked, cycles;
	logic [7:0] q;

	// ****************************************************************
	// clock, wiring and helpers
	// ****************************************************************
	always #10 clk_in = ~clk_in;
	assign sdo_w = oe_n ? 1'bz : sdo; // undriven line floats, so a wrong enable shows
	fcis_core u_dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .clk_en_in(clk_en),
		.spi_sclk_in(sclk), .spi_cs_n_in(cs_n), .spi_sdi_in(sdi), .fast_latch_sel_in(fast_latch_sel),
		.spi_sdo_out(sdo), .spi_sdo_oe_n_out(oe_n), .center_cap_code_out(cc),
		.bandwidth_cap_code_out(bc), .match_cap_code_out(mc));
	fcis_host u_host (.sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi), .sfl_out(fast_latch_sel),
		.sdo_in(sdo_w));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		u_host.frame(1'b0, a, d, q);
	endtask : wr
	task automatic rd_chk(input logic [14:0] a, input logic [7:0] exp);
		u_host.frame(1'b1, a, 8'h00, q);
		chk(q, exp);
	endtask : rd_chk
	task automatic grp(input int p);
		chk(cc, 8'(8'h40 + p));
		chk(bc, 8'(8'h60 + p));
		chk(mc, 8'(8'h80 + p));
	endtask : grp

	// reference interpolation, signed so negative slopes floor
	function automatic int yv(int i);
		return int'(fcis_pkg::FC_COEFF_RESET[i]);
	endfunction : yv
	function automatic int fc(int x);
		int k;
		k = x / 32 + 1;
		if (x < 16) return yv(1) + (((16 - x) * (yv(0) - yv(1))) >>> 4);
		if (x < 32) return yv(2) + (((32 - x) * (yv(1) - yv(2))) >>> 4);
		if (x < 255) return yv(k + 1) + (((k * 32 - x) * (yv(k) - yv(k + 1))) >>> 5);
		return yv(9);
	endfunction : fc
	function automatic logic [7:0] knee(int y, int c0, int c1, int c2);
		if (y < 32) return 8'(c0 + ((y * (c1 - c0)) >>> 5));
		if (y < 255) return 8'(c1 + (((y - 32) * (c2 - c1) * 295) >>> 16));
		return 8'(c2);
	endfunction : knee

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_reset();
		chk(cc, 8'h00);
		rd_chk(fcis_pkg::ADDR_STOP, 8'h7f);
		rd_chk(fcis_pkg::ADDR_START, 8'h00);
		rd_chk(fcis_pkg::ADDR_DIR, 8'h00);
		rd_chk(fcis_pkg::ADDR_FC_COEFF, 8'hdb);
		rd_chk(15'h0000, 8'h00);
		wr(fcis_pkg::ADDR_PTR, 8'h1f);
		rd_chk(fcis_pkg::ADDR_PTR, 8'h00);
	endtask : t_reset

	task automatic t_pass();
		wr(fcis_pkg::ADDR_WR_CENTER, 8'hab);
		wr(fcis_pkg::ADDR_WR_BW, 8'hcd);
		wr(fcis_pkg::ADDR_WR_MATCH, 8'hef);
		chk(cc, 8'hab);
		chk(bc, 8'hcd);
		chk(mc, 8'hef);
		wr(fcis_pkg::ADDR_APP_CENTER, 8'h00);
		rd_chk(fcis_pkg::ADDR_APP_CENTER, 8'hab);
		rd_chk(fcis_pkg::ADDR_APP_BW, 8'hcd);
		rd_chk(fcis_pkg::ADDR_APP_MATCH, 8'hef);
	endtask : t_pass

	task automatic t_interp();
		int xs[12] = '{0, 15, 16, 18, 31, 32, 100, 180, 200, 224, 254, 255};
		logic [7:0] y;
		wr(fcis_pkg::ADDR_INTERP, 8'h01);
		foreach (xs[i]) begin
			wr(fcis_pkg::ADDR_WR_CENTER, 8'(xs[i]));
			y = 8'(fc(xs[i]));
			chk(cc, y);
			chk(bc, knee(y, 0, 4, 29));
			chk(mc, knee(y, 0, 17, 106));
		end
		rd_chk(fcis_pkg::ADDR_APP_CENTER, y);
		// coefficient 9 at full scale drives the knee curves to their top branch
		wr(fcis_pkg::ADDR_FC_LAST, 8'hff);
		chk(cc, 8'hff);
		chk(bc, 8'h1d);
		chk(mc, 8'h6a);
		wr(fcis_pkg::ADDR_INTERP, 8'h00);
		chk(cc, 8'hff);
	endtask : t_interp

	task automatic t_seq();
		for (int p = 2; p < 5; p++) begin
			for (int b = 0; b < 3; b++) begin
				wr(15'(fcis_pkg::ADDR_LUT_FIRST + 3 * p + b), 8'(8'h40 + 32 * b + p));
			end
		end
		wr(fcis_pkg::ADDR_START, 8'h02);
		wr(fcis_pkg::ADDR_STOP, 8'h04);
		wr(fcis_pkg::ADDR_DIR, 8'h00);
		rd_chk(fcis_pkg::ADDR_PTR, 8'h02);
		u_host.set_sfl(1'b1);
		u_host.pulse();
		grp(2);
		rd_chk(fcis_pkg::ADDR_PTR, 8'h03);
		grp(3);
		u_host.pulse();
		grp(4);
		rd_chk(fcis_pkg::ADDR_PTR, 8'h02);
		u_host.set_sfl(1'b0);
		wr(fcis_pkg::ADDR_DIR, 8'h01);
		rd_chk(fcis_pkg::ADDR_PTR, 8'h04);
		u_host.set_sfl(1'b1);
		u_host.pulse();
		grp(4);
		u_host.pulse();
		u_host.pulse();
		grp(2);
		rd_chk(fcis_pkg::ADDR_PTR, 8'h04);
		u_host.set_sfl(1'b0);
		u_host.pulse();
		chk(cc, 8'hff);
	endtask : t_seq

	// a write made while the core clock is gated must wait for the enable
	task automatic t_hold();
		@(negedge clk_in) clk_en = 1'b0;
		wr(fcis_pkg::ADDR_WR_CENTER, 8'h5a);
		chk(cc, 8'hff);
		@(negedge clk_in) clk_en = 1'b1;
		repeat (8) @(negedge clk_in);
		chk(cc, 8'h5a);
	endtask : t_hold

	// ****************************************************************
	// run control
	// ****************************************************************
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : test_done

	// hang guard, well above the roughly nine thousand cycles the run needs
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 40000) begin
			fails++;
			test_done();
		end
	end

	initial begin
		repeat (16) @(posedge clk_in);
		@(negedge clk_in);
		arst_n_in = 1'b1;
		repeat (4) @(negedge clk_in);
		t_reset();
		t_pass();
		t_interp();
		t_seq();
		t_hold();
		test_done();
	end
endmodule : filter_code_interp_sequencer_bench
`default_nettype wire
